// ---- src/sleep_pkg.sv ----
// Shared constants for the block sleep handshake and its register map
package sleep_pkg;
  localparam int NUM_SEG = 2;
  localparam int BLK_PER_SEG = 4;
  localparam int NUM_BLK = NUM_SEG * BLK_PER_SEG;
  // Register offsets (byte addresses, APB)
  localparam logic [7:0] OFS_SLEEP_EN = 8'h08;
  localparam logic [7:0] OFS_CLK_REQ_STS = 8'h0C;
  localparam logic [7:0] OFS_SYS_SLEEP = 8'h18;
  localparam logic [7:0] OFS_RESET_EN = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h4C;
  // System sleep control fields
  localparam int SYS_STATE_LSB = 0;
  localparam int SYS_SLEEP_ALL_BIT = 3;
  localparam int SYS_SLEEP_DEBUG_BIT = 4;
  localparam int SYS_AUTO_CLR_BIT = 5;
  // Status register fields
  localparam int STS_SLEEPING_BIT = 1;
  localparam int STS_OSC_RUN_BIT = 2;
  // Debug command that reads the sleeping flag
  localparam logic [7:0] DBG_CMD_SLEEP_STS = 8'h07;
  // Reset values
  localparam logic [31:0] SLEEP_EN_RST = 32'h0000_0000;
  localparam logic [31:0] SYS_SLEEP_RST = 32'h0000_0000;
  localparam logic [31:0] RESET_EN_RST = 32'h0000_0000;
  // Wake pulse length in cycles
  localparam int WAKE_PULSE_CYC = 2;
  // Longest busy-to-idle time of a block
  localparam int BUSY_DRAIN_US = 1000;
  localparam int CLK_MHZ = 50;
  localparam int BUSY_DRAIN_CYC = BUSY_DRAIN_US * CLK_MHZ;
  // Chip sleep state encodings
  typedef enum logic [1:0] {
    heavy_sleep_1, heavy_sleep_2, heavy_sleep_3, deepest_sleep
  } sleep_state_e;
endpackage : sleep_pkg

// ---- src/sleep_if.sv ----
// Sleep handshake wires between the power manager and its blocks
`timescale 1ns/100ps
`default_nettype none
interface sleep_if;
  logic [sleep_pkg::NUM_BLK-1:0] sleep_req;
  logic [sleep_pkg::NUM_BLK-1:0] reset_on_sleep;
  logic [sleep_pkg::NUM_BLK-1:0] clk_req;
  logic [sleep_pkg::NUM_SEG-1:0] seg_clk_en;
  modport manager (
    output sleep_req,
    output reset_on_sleep,
    output seg_clk_en,
    input clk_req
  );
  modport blocks (
    input sleep_req,
    input reset_on_sleep,
    input seg_clk_en,
    output clk_req
  );
endinterface : sleep_if
`default_nettype wire

// ---- src/sync3.sv ----
// Three flip-flop synchroniser with agreement of the last two stages
`timescale 1ns/100ps
`default_nettype none
module sync3 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // Shift chain; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Output changes only where stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= (s2 & s3) | (q & (s2 | s3));
    end
  end
endmodule : sync3
`default_nettype wire

// ---- src/sleep_manager.sv ----
// Power manager end: sleep requests, clock gating and chip sleep control
// Contract
// - One sleep request per block, per segment
// - Blocks drive clock requests; manager watches them
// - Reset-on-sleep resets block entering sleep
// - Blocks raise clock request only asynchronously; here a work request rises from the registered busy flag on a pclk edge
// - Idle block holds clock request low
// - Idle block sleeps at once on request
// - Busy block finishes, drops request within 1 ms
// - Register accesses always serviced during sleep
// - Wake event momentarily clears all sleep enables
// - Sleep needs all asleep, no requests, instruction
// - Firmware selects sleep state before sleep instruction
// - Sleep all bit or every enable commands
// - Readable clock-required bit per block
// - Timers and PWMs drop request immediately
// - Oscillator runs only in heavy sleep 1
// - Oscillator routable to test clock output
// - Sleeping flag bit 1 via debug command 0x07
// - Any debugger processor access wakes chip
// - Sleep holds until wake, debug, or reset
// - Wake group turns clocks on, interrupts processor
// - Wake-only group restarts oscillator, no interrupt
// - Auto-clear drops sleep-all, debug on vector
`timescale 1ns/100ps
`default_nettype none
module sleep_manager (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sleep_if.manager sl,
  input wire logic cpu_sleep_insn,
  input wire logic cpu_int_vector,
  input wire logic wake_int_event,
  input wire logic wake_only_event,
  input wire logic dbg_cmd_valid,
  input wire logic [7:0] dbg_cmd,
  input wire logic dbg_cpu_access,
  input wire logic test_clk_sel,
  output logic [31:0] dbg_rdata,
  output logic cpu_irq,
  output logic osc_run,
  output logic test_clock_output,
  output logic chip_sleeping
);
  localparam int NB = sleep_pkg::NUM_BLK;
  localparam int BPS = sleep_pkg::BLK_PER_SEG;
  typedef enum {st_run, st_sleep, st_wake} chip_e;
  chip_e chip_st;
  logic [NB-1:0] sleep_en;
  logic [NB-1:0] reset_en;
  logic [5:0] sys_ctl;
  logic [NB-1:0] clk_req_s;
  logic [2:0] ev_s;
  logic [2:0] ev_q;
  logic [1:0] wake_cnt;
  logic osc_div;
  logic wr_en;
  logic wake_any;
  logic all_cmd;
  logic all_idle;

  // Byte offset match
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : hit

  // Asynchronous block requests and wake pins are synchronised
  sync3 #(.W(NB)) u_req (
    .pclk(pclk),
    .presetn(presetn),
    .d(sl.clk_req),
    .q(clk_req_s)
  );
  sync3 #(.W(3)) u_ev (
    .pclk(pclk),
    .presetn(presetn),
    .d({dbg_cpu_access, wake_only_event, wake_int_event}),
    .q(ev_s)
  );

  // Previous synced events; a held level wakes only once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_q <= '0;
    end else begin
      ev_q <= ev_s;
    end
  end

  // Decode
  assign wr_en = psel & penable & pwrite;
  assign wake_any = |(ev_s & ~ev_q);
  assign all_cmd = sys_ctl[sleep_pkg::SYS_SLEEP_ALL_BIT] | (&sleep_en);
  assign all_idle = ~|clk_req_s;

  // Sleep enables and reset enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_en <= sleep_pkg::SLEEP_EN_RST[NB-1:0];
      reset_en <= sleep_pkg::RESET_EN_RST[NB-1:0];
    end else if (wr_en) begin
      if (hit(paddr, sleep_pkg::OFS_SLEEP_EN)) begin
        sleep_en <= pwdata[NB-1:0];
      end
      if (hit(paddr, sleep_pkg::OFS_RESET_EN)) begin
        reset_en <= pwdata[NB-1:0];
      end
    end
  end

  // System sleep control with auto clear on vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_ctl <= sleep_pkg::SYS_SLEEP_RST[5:0];
    end else if (wr_en && hit(paddr, sleep_pkg::OFS_SYS_SLEEP)) begin
      sys_ctl <= pwdata[5:0];
    end else if (cpu_int_vector && sys_ctl[sleep_pkg::SYS_AUTO_CLR_BIT]) begin
      sys_ctl[sleep_pkg::SYS_SLEEP_ALL_BIT] <= 1'b0;
      sys_ctl[sleep_pkg::SYS_SLEEP_DEBUG_BIT] <= 1'b0;
    end
  end

  // Chip sleep state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_st <= st_run;
      wake_cnt <= '0;
    end else begin
      case (chip_st)
        st_run: begin
          if (wake_any) begin
            chip_st <= st_wake;
            wake_cnt <= 2'(sleep_pkg::WAKE_PULSE_CYC - 1);
          end else if (all_cmd && all_idle && cpu_sleep_insn) begin
            chip_st <= st_sleep;
          end
        end
        st_sleep: begin
          if (wake_any) begin
            chip_st <= st_wake;
            wake_cnt <= 2'(sleep_pkg::WAKE_PULSE_CYC - 1);
          end
        end
        st_wake: begin
          if (wake_cnt == '0) begin
            chip_st <= st_run;
          end else begin
            wake_cnt <= wake_cnt - 2'd1;
          end
        end
        default: chip_st <= st_run;
      endcase
    end
  end

  // Sleep requests and reset-on-sleep; cleared during a wake pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sl.sleep_req <= '0;
      sl.reset_on_sleep <= '0;
    end else begin
      sl.sleep_req <= (chip_st == st_wake || wake_any) ? '0 :
        (sys_ctl[sleep_pkg::SYS_SLEEP_ALL_BIT] ? '1 : sleep_en);
      sl.reset_on_sleep <= reset_en & sl.sleep_req & ~clk_req_s;
    end
  end

  // Segment gating: every block asleep and idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sl.seg_clk_en <= '1;
    end else begin
      for (int s = 0; s < sleep_pkg::NUM_SEG; s++) begin
        sl.seg_clk_en[s] <= ~(&(sl.sleep_req[s*BPS +: BPS]
          & ~clk_req_s[s*BPS +: BPS]));
      end
    end
  end

  // Oscillator run, test clock and sleeping flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_run <= 1'b1;
      osc_div <= 1'b0;
      test_clock_output <= 1'b0;
      chip_sleeping <= 1'b0;
      cpu_irq <= 1'b0;
      dbg_rdata <= '0;
    end else begin
      osc_run <= chip_st != st_sleep || sys_ctl[1:0] ==
        2'(sleep_pkg::heavy_sleep_1) || ev_s[1];
      osc_div <= osc_div ^ osc_run;
      test_clock_output <= test_clk_sel & osc_div;
      chip_sleeping <= chip_st == st_sleep;
      cpu_irq <= ev_s[0];
      if (dbg_cmd_valid && dbg_cmd == sleep_pkg::DBG_CMD_SLEEP_STS) begin
        dbg_rdata <= 32'(chip_st == st_sleep) <<
          sleep_pkg::STS_SLEEPING_BIT;
      end
    end
  end

  // APB read path, zero wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          sleep_pkg::OFS_SLEEP_EN: prdata <= 32'(sleep_en);
          sleep_pkg::OFS_CLK_REQ_STS: prdata <= 32'(clk_req_s);
          sleep_pkg::OFS_SYS_SLEEP: prdata <= 32'(sys_ctl);
          sleep_pkg::OFS_RESET_EN: prdata <= 32'(reset_en);
          sleep_pkg::OFS_STATUS: prdata <= {29'h0, osc_run,
            chip_st == st_sleep, 1'b0};
          default: pslverr <= 1'b1;
        endcase
      end else if (psel && !penable) begin
        pslverr <= !(hit(paddr, sleep_pkg::OFS_SLEEP_EN) ||
          hit(paddr, sleep_pkg::OFS_SYS_SLEEP) ||
          hit(paddr, sleep_pkg::OFS_RESET_EN));
      end
    end
  end
endmodule : sleep_manager
`default_nettype wire

// ---- src/sleep_blocks.sv ----
// Peripheral end: per-block clock request behaviour under sleep
`timescale 1ns/100ps
`default_nettype none
module sleep_blocks (
  input wire logic pclk,
  input wire logic presetn,
  sleep_if.blocks sl,
  input wire logic [sleep_pkg::NUM_BLK-1:0] work_pending,
  input wire logic [sleep_pkg::NUM_BLK-1:0] reg_access,
  input wire logic [sleep_pkg::NUM_BLK-1:0] simple_block,
  output logic [sleep_pkg::NUM_BLK-1:0] block_asleep,
  output logic [sleep_pkg::NUM_BLK-1:0] block_reset
);
  localparam int NB = sleep_pkg::NUM_BLK;
  logic [NB-1:0] busy;
  logic [NB-1:0] locked;

  // Work tracking; simple blocks drop work on a sleep request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= '0;
      locked <= '0;
      block_asleep <= '0;
      block_reset <= '0;
    end else begin
      for (int b = 0; b < NB; b++) begin
        if (!sl.sleep_req[b]) begin
          locked[b] <= 1'b0;
          busy[b] <= work_pending[b];
        end else if (simple_block[b] || !busy[b]) begin
          locked[b] <= 1'b1;
          busy[b] <= 1'b0;
        end else begin
          busy[b] <= work_pending[b];
        end
      end
      block_asleep <= locked;
      block_reset <= locked & sl.reset_on_sleep;
    end
  end

  // Request follows access combinationally; work part rises and drops on pclk
  always_comb begin
    sl.clk_req = (busy & ~locked) | reg_access;
  end
endmodule : sleep_blocks
`default_nettype wire

// ---- dv/sleep_chk_sva.sv ----
// Concurrent checks on the sleep handshake wires
`timescale 1ns/100ps
`default_nettype none
module sleep_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [sleep_pkg::NUM_BLK-1:0] sleep_req,
  input wire logic [sleep_pkg::NUM_BLK-1:0] clk_req,
  input wire logic [sleep_pkg::NUM_SEG-1:0] seg_clk_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Idle state straight after reset
  property p_rst;
    $rose(presetn) |-> seg_clk_en == 2'h3 && sleep_req == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  // A segment with an awake block keeps its clock
  property p_on0;
    !(&sleep_req[3:0]) |-> ##[0:1] seg_clk_en[0];
  endproperty
  a_on0: assert property (p_on0) else $error("seg 0 gated early");
  property p_on1;
    !(&sleep_req[7:4]) |-> ##[0:1] seg_clk_en[1];
  endproperty
  a_on1: assert property (p_on1) else $error("seg 1 gated early");
  // Gating only follows a full sleep command
  property p_off0;
    $fell(seg_clk_en[0]) |-> &sleep_req[3:0] || $past(&sleep_req[3:0]);
  endproperty
  a_off0: assert property (p_off0) else $error("seg 0 bad gate");
  property p_off1;
    $fell(seg_clk_en[1]) |-> &sleep_req[7:4] || $past(&sleep_req[7:4]);
  endproperty
  a_off1: assert property (p_off1) else $error("seg 1 bad gate");
  // A steady clock request holds the segment on
  property p_busy0;
    (|clk_req[3:0]) [*6] |-> ##[0:1] seg_clk_en[0];
  endproperty
  a_busy0: assert property (p_busy0) else $error("seg 0 busy gated");
  property p_busy1;
    (|clk_req[7:4]) [*6] |-> ##[0:1] seg_clk_en[1];
  endproperty
  a_busy1: assert property (p_busy1) else $error("seg 1 busy gated");
  // Wake clears the requests only briefly
  property p_wake;
    sleep_req == 8'hFF ##1 sleep_req == 8'h00 |-> ##[1:6] sleep_req == 8'hFF;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not restored");
  c_gate: cover property (!seg_clk_en[0]);
  c_wake: cover property (sleep_req == 8'hFF ##1 sleep_req == 8'h00);
  c_busy: cover property (clk_req[4] && (&sleep_req[7:4]));
endmodule : sleep_chk
`default_nettype wire

// ---- dv/block_sleep_handshake_manager_tb.sv ----
// Bench joining manager and blocks across the sleep interface
`timescale 1ns/100ps
`default_nettype none
module block_sleep_handshake_manager_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, t0;
  logic [7:0] paddr, dbg_cmd, work_pending, reg_access, simple_block;
  logic [7:0] block_asleep, block_reset;
  logic [31:0] pwdata, prdata, dbg_rdata, rd;
  logic cpu_sleep_insn, cpu_int_vector, wake_int_event, wake_only_event;
  logic dbg_cmd_valid, dbg_cpu_access, test_clk_sel, cpu_irq, osc_run;
  logic test_clock_output, chip_sleeping;
  int bad_count = 0;
  int total_checks = 0;
  sleep_if sl_bus ();
  sleep_manager u_sleep_manager (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sl(sl_bus), .cpu_sleep_insn(cpu_sleep_insn),
    .cpu_int_vector(cpu_int_vector), .wake_int_event(wake_int_event),
    .wake_only_event(wake_only_event), .dbg_cmd_valid(dbg_cmd_valid),
    .dbg_cmd(dbg_cmd), .dbg_cpu_access(dbg_cpu_access),
    .test_clk_sel(test_clk_sel), .dbg_rdata(dbg_rdata), .cpu_irq(cpu_irq),
    .osc_run(osc_run), .test_clock_output(test_clock_output),
    .chip_sleeping(chip_sleeping));
  sleep_blocks u_sleep_blocks (.pclk(pclk), .presetn(presetn), .sl(sl_bus),
    .work_pending(work_pending), .reg_access(reg_access),
    .simple_block(simple_block), .block_asleep(block_asleep),
    .block_reset(block_reset));
  sleep_chk u_sleep_chk (.pclk(pclk), .presetn(presetn),
    .sleep_req(sl_bus.sleep_req), .clk_req(sl_bus.clk_req),
    .seg_clk_en(sl_bus.seg_clk_en));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic settle;
    repeat (12) @(posedge pclk);
  endtask : settle
  // Reset values and register access kinds
  task automatic t_regs;
    apb(1'b0, sleep_pkg::OFS_SLEEP_EN, 32'h0);
    chk(rd, sleep_pkg::SLEEP_EN_RST);
    apb(1'b0, sleep_pkg::OFS_SYS_SLEEP, 32'h0);
    chk(rd, sleep_pkg::SYS_SLEEP_RST);
    chk(32'(osc_run), 32'h1);
    apb(1'b1, sleep_pkg::OFS_CLK_REQ_STS, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, sleep_pkg::OFS_RESET_EN, 32'hA5);
    apb(1'b0, sleep_pkg::OFS_RESET_EN, 32'h0);
    chk(rd, 32'hA5);
    // No block is asleep yet, so no reset goes out
    chk(32'(sl_bus.reset_on_sleep), 32'h0);
  endtask : t_regs
  // Per-segment gating with busy, simple and accessed blocks
  task automatic t_seg;
    apb(1'b1, sleep_pkg::OFS_SLEEP_EN, 32'h0F);
    settle;
    chk(32'(sl_bus.sleep_req), 32'h0F);
    chk(32'(sl_bus.seg_clk_en), 32'h2);
    chk(32'(sl_bus.reset_on_sleep), 32'h05);
    chk(32'(block_asleep), 32'h0F);
    chk(32'(block_reset), 32'h05);
    work_pending <= 8'h50;
    simple_block <= 8'h40;
    settle;
    chk(32'(sl_bus.clk_req), 32'h50);
    apb(1'b1, sleep_pkg::OFS_SLEEP_EN, 32'hFF);
    settle;
    apb(1'b0, sleep_pkg::OFS_CLK_REQ_STS, 32'h0);
    chk(rd, 32'h10);
    chk(32'(sl_bus.seg_clk_en), 32'h2);
    work_pending <= 8'h00;
    settle;
    chk(32'(sl_bus.seg_clk_en), 32'h0);
    reg_access <= 8'h22;
    settle;
    apb(1'b0, sleep_pkg::OFS_CLK_REQ_STS, 32'h0);
    chk(rd, 32'h22);
    chk(32'(sl_bus.seg_clk_en), 32'h3);
    reg_access <= 8'h00;
    settle;
  endtask : t_seg
  // Every sleep state, debug status read, wake-only event
  task automatic t_sleep;
    test_clk_sel <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, sleep_pkg::OFS_SYS_SLEEP, 32'(s));
      settle;
      chk(32'(chip_sleeping), 32'h0);
      cpu_sleep_insn <= 1'b1;
      settle;
      chk(32'(chip_sleeping), 32'h1);
      chk(32'(osc_run), 32'(s == 0));
      apb(1'b0, sleep_pkg::OFS_STATUS, 32'h0);
      chk(rd, (s == 0) ? 32'h6 : 32'h2);
      t0 = test_clock_output;
      dbg_cmd <= sleep_pkg::DBG_CMD_SLEEP_STS;
      dbg_cmd_valid <= 1'b1;
      @(posedge pclk);
      dbg_cmd_valid <= 1'b0;
      @(posedge pclk);
      chk(32'({dbg_rdata[1], chip_sleeping}), 32'h3);
      // Three edges on: a running clock shows the inverse
      @(posedge pclk);
      chk(32'(test_clock_output), 32'((s == 0) ? !t0 : t0));
      wake_only_event <= 1'b1;
      cpu_sleep_insn <= 1'b0;
      settle;
      chk(32'({osc_run, cpu_irq, chip_sleeping}), 32'h4);
      wake_only_event <= 1'b0;
      settle;
    end
    cpu_sleep_insn <= 1'b1;
    settle;
    chk(32'(chip_sleeping), 32'h1);
    // Processor leaves its sleep instruction once woken
    dbg_cpu_access <= 1'b1;
    cpu_sleep_insn <= 1'b0;
    settle;
    chk(32'({osc_run, chip_sleeping}), 32'h2);
    dbg_cpu_access <= 1'b0;
    settle;
  endtask : t_sleep
  // Wake event with interrupt, then auto-clear on vector
  task automatic t_wake;
    wake_int_event <= 1'b1;
    // Mid-pulse: synchroniser plus one edge, enables cleared
    repeat (6) @(posedge pclk);
    chk(32'(sl_bus.sleep_req), 32'h00);
    repeat (6) @(posedge pclk);
    chk(32'(cpu_irq), 32'h1);
    chk(32'(sl_bus.sleep_req), 32'hFF);
    wake_int_event <= 1'b0;
    apb(1'b1, sleep_pkg::OFS_SLEEP_EN, 32'h0F);
    apb(1'b1, sleep_pkg::OFS_SYS_SLEEP, 32'h38);
    settle;
    chk(32'(sl_bus.sleep_req), 32'hFF);
    chk(32'(cpu_irq), 32'h0);
    cpu_int_vector <= 1'b1;
    @(posedge pclk);
    cpu_int_vector <= 1'b0;
    settle;
    apb(1'b0, sleep_pkg::OFS_SYS_SLEEP, 32'h0);
    chk(rd, 32'h20);
    chk(32'(sl_bus.sleep_req), 32'h0F);
  endtask : t_wake
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks=%0d bad=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // Clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, cpu_sleep_insn, cpu_int_vector} = '0;
    {wake_int_event, wake_only_event, dbg_cmd_valid, dbg_cpu_access} = '0;
    {test_clk_sel, paddr, dbg_cmd, pwdata} = '0;
    {work_pending, reg_access, simple_block} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_seg;
    t_sleep;
    t_wake;
    tally_and_finish;
  end
endmodule : block_sleep_handshake_manager_tb
`default_nettype wire
